// ==== bench/sdpz_feed.sv ====
// Far-side model: sample feed, central time source and output sink
`timescale 1ns/1ps
module sdpz_feed (
  // Clock
  input  wire logic        clk,
  // Central time and output slots
  output logic [47:0]      ct_time,
  output logic             ct_tick,
  // Samples toward the block
  output logic             in_valid,
  output logic [47:0]      in_ts,
  output logic [15:0]      in_data,
  // Conditioned stream from the block
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data
);
  int          n_out;   // Output samples seen
  int          n_rep;   // Outputs equal to the one before
  logic [31:0] last_q;  // Previous output word

  // Idle values at time zero
  initial
  begin
    ct_time  = 48'h0;
    ct_tick  = 1'b0;
    in_valid = 1'b0;
    in_ts    = 48'h0;
    in_data  = 16'h0;
    n_out    = 0;
    n_rep    = 0;
    last_q   = 32'h0;
  end

  // Sample word is tied to the timestamp, so a misplaced word shows up
  task automatic send(input logic [47:0] ts);
    @(posedge clk);
    in_valid <= 1'b1;
    in_ts    <= ts;
    in_data  <= {ts[7:0], ~ts[7:0]};
    @(posedge clk);
    // Released lines show the inverse, not a stale copy
    in_valid <= 1'b0;
    in_ts    <= ~ts;
    in_data  <= ~{ts[7:0], ~ts[7:0]};
  endtask

  // Step central time to a new value
  task automatic set_time(input logic [47:0] t);
    @(posedge clk);
    ct_time <= t;
    repeat (4) @(posedge clk);
  endtask

  // Back to back output slots, then let the pipeline drain
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ct_tick <= 1'b1;
    end
    @(posedge clk);
    ct_tick <= 1'b0;
    repeat (16) @(posedge clk);
  endtask

  // Restart the output counters while the stream is quiet
  task automatic clear();
    @(posedge clk);
    n_out <= 0;
    n_rep <= 0;
  endtask

  // Sink: count outputs and repeats of the previous word
  always @(posedge clk)
  begin
    if (out_valid === 1'b1)
    begin
      n_out  <= n_out + 1;
      if (out_data === last_q)
        n_rep <= n_rep + 1;
      last_q <= out_data;
    end
  end
endmodule

// ==== bench/test_subband_delay_phase_zoom.sv ====
// Self-checking bench for the sub-band delay, phase and zoom path
`timescale 1ns/1ps
module test_subband_delay_phase_zoom;
  logic        clk;              // 250 MHz clock
  logic        rst;              // Synchronous reset
  logic        ce;               // Clock enable, high except during the freeze test
  logic [47:0] ct_time;          // Central time
  logic        ct_tick;          // Output slot strobe
  logic        in_valid;         // Sample strobe
  logic [47:0] in_ts;            // Sample timestamp
  logic [15:0] in_data;          // Sample word
  logic        out_valid;        // Output strobe
  logic [31:0] out_data;         // Output word
  logic [3:0]  avs_address;      // Bus word index
  logic        avs_read;         // Bus read
  logic        avs_write;        // Bus write
  logic [31:0] avs_writedata;    // Bus write word
  logic [31:0] avs_readdata;     // Bus read word
  logic        avs_waitrequest;  // Bus stall
  logic [31:0] rd;               // Last word read
  int          n_fail;           // Mismatches
  int          check_count;      // Comparisons

  // Small buffer and short late window keep the run brief
  sdpz_top #(.BUF_AW(8), .LATE_WIN(48'h64)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .ct_time(ct_time), .ct_tick(ct_tick),
    .in_valid(in_valid), .in_ts(in_ts), .in_data(in_data),
    .out_valid(out_valid), .out_data(out_data),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // Far side
  sdpz_feed i_feed (
    .clk(clk), .ct_time(ct_time), .ct_tick(ct_tick), .in_valid(in_valid),
    .in_ts(in_ts), .in_data(in_data), .out_valid(out_valid), .out_data(out_data));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #160000;
    n_fail++;
    close_out();
  end

  // Main sequence
  initial
  begin
    int a;
    int e;
    int m;
    int z;
    int zl[4];
    int nt[4];
    int no[4];
    zl = '{19, 99, 115, 27};
    nt = '{16, 128, 128, 16};
    no = '{8, 2, 2, 16};
    rst = 1'b1;
    ce = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, avs_waitrequest}, 32'h1);
    // Every word reads zero out of reset, unmapped ones included
    for (a = 0; a < 16; a++)
    begin
      bus(1'b0, 4'(a), 32'h0);
      chk(rd, 32'h0);
    end
    // Unmapped write is ignored
    bus(1'b1, 4'he, 32'hffff_ffff);
    bus(1'b0, 4'he, 32'h0);
    chk(rd, 32'h0);
    // Every resampler filter passes tap 0 only, gain high enough that
    // neighbouring samples stay distinct after the mixer
    for (a = 0; a < 4096; a++)
      bus(1'b1, sdpz_pkg::REG_RS_COEF, {4'h0, 10'(a >> 2), 2'(a), (a % 4 == 0) ? 16'h4000 : 16'h0000});
    for (a = 0; a < 32; a++)
      bus(1'b1, sdpz_pkg::REG_ZM_COEF, {11'h0, 3'(a >> 2), 2'(a), 16'h0040});
    bus(1'b0, sdpz_pkg::REG_RS_COEF, 32'h0);
    chk(rd, 32'h0);
    // Fill the buffer partly in reverse order
    for (a = 255; a >= 128; a--)
      i_feed.send(48'(a));
    for (a = 0; a < 128; a++)
      i_feed.send(48'(a));
    // Age 101 is dropped, age 100 is kept
    i_feed.set_time(48'h3e8);
    i_feed.send(48'h383);
    bus(1'b0, sdpz_pkg::REG_STATUS, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h1);
    i_feed.send(48'h384);
    bus(1'b0, sdpz_pkg::REG_STATUS, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h1);
    // Constant model, no drift, armed for a later time
    bus(1'b1, sdpz_pkg::REG_C0, 32'h0005_0000);
    for (a = 3; a < 10; a++)
      if (a != 5)
        bus(1'b1, 4'(a), 32'h0);
    bus(1'b1, sdpz_pkg::REG_TAPPLY, 32'h3f2);
    bus(1'b0, sdpz_pkg::REG_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    // Slots before the apply time produce nothing
    bus(1'b1, sdpz_pkg::REG_CTRL, 32'h1);
    i_feed.clear();
    i_feed.ticks(8);
    chk(32'(i_feed.n_out), 32'h0);
    i_feed.set_time(48'h3f2);
    bus(1'b0, sdpz_pkg::REG_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    bus(1'b0, sdpz_pkg::REG_DELAY, 32'h0);
    chk(rd, 32'h0005_0000);
    bus(1'b0, sdpz_pkg::REG_TIME, 32'h0);
    chk(rd, 32'h3f2);
    // 512 slots: one output each, about one hold per 42.7 slots
    i_feed.clear();
    i_feed.ticks(512);
    chk(32'(i_feed.n_out), 32'd512);
    chk({31'h0, i_feed.n_rep >= 11 && i_feed.n_rep <= 13}, 32'h1);
    // Zoom engages only when enabled, in the two allowed modes, factor above 1
    for (e = 0; e < 2; e++)
      for (m = 0; m < 3; m++)
        for (z = 0; z < 8; z++)
        begin
          bus(1'b1, sdpz_pkg::REG_CTRL, 32'(1 + 2 * e + 4 * m + 16 * z));
          bus(1'b0, sdpz_pkg::REG_STATUS, 32'h0);
          chk({31'h0, rd[2]}, {31'h0, e == 1 && m < 2 && z > 0});
        end
    // Decimation by 2, by 64, factor field above 6 treated as 64, none in other mode
    for (a = 0; a < 4; a++)
    begin
      bus(1'b1, sdpz_pkg::REG_CTRL, 32'(zl[a]));
      i_feed.clear();
      i_feed.ticks(nt[a]);
      chk(32'(i_feed.n_out), 32'(no[a]));
    end
    // Clock enable low freezes the path, slots pass unseen, then it resumes
    @(posedge clk);
    ce <= 1'b0;
    i_feed.clear();
    i_feed.ticks(8);
    chk(32'(i_feed.n_out), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    i_feed.clear();
    i_feed.ticks(8);
    chk(32'(i_feed.n_out), 32'h8);
    // Stopped path ignores slots
    bus(1'b1, sdpz_pkg::REG_CTRL, 32'h0);
    i_feed.clear();
    i_feed.ticks(8);
    chk(32'(i_feed.n_out), 32'h0);
    // Reset in mid-run clears the model, the drop count and the bus
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, avs_waitrequest}, 32'h1);
    bus(1'b0, sdpz_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule

// ==== hw/sdpz_pkg.sv ====
// Constants for the sub-band delay, phase and zoom path
package sdpz_pkg;
  // Rates: one input sample per clock, outputs paced by central time
  localparam int CLK_MHZ = 250;
  localparam int OUT_MHZ = 256;
  localparam int CLK_PS  = 1000000 / CLK_MHZ;
  // Residual delay decrement per output slot, held or not, in femtoseconds
  localparam longint STEP_FS = 93750;
  // Same step as a fraction of one input sample, scale 2^-32
  localparam logic [31:0] RS_STEP = 32'((STEP_FS << 32) / (longint'(CLK_PS) * 1000));
  // Oldest accepted packet age
  localparam int     LATE_MS   = 250;
  localparam longint LATE_SAMP = longint'(LATE_MS) * CLK_MHZ * 1000;
  // Filter banks and channelizer
  localparam int TAPS       = 4;
  localparam int RS_BANK    = 1024;
  localparam int RS_IW      = 10;
  localparam int ZM_MAX_LOG = 6;
  localparam int CHANS      = 16384;
  // Register word indices
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_C0      = 4'h2;
  localparam logic [3:0] REG_C1      = 4'h3;
  localparam logic [3:0] REG_C2      = 4'h4;
  localparam logic [3:0] REG_TAPPLY  = 4'h5;
  localparam logic [3:0] REG_PH_FREQ = 4'h6;
  localparam logic [3:0] REG_PH_INIT = 4'h7;
  localparam logic [3:0] REG_ZM_FREQ = 4'h8;
  localparam logic [3:0] REG_ZM_INIT = 4'h9;
  localparam logic [3:0] REG_RS_COEF = 4'ha;
  localparam logic [3:0] REG_ZM_COEF = 4'hb;
  localparam logic [3:0] REG_DELAY   = 4'hc;
  localparam logic [3:0] REG_TIME    = 4'hd;
  // Control fields
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_ZEN  = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_ZLOG = 4;
  // Coefficient write fields
  localparam int COEF_TAP = 16;
  localparam int COEF_IDX = 18;
  // Observing modes
  localparam logic [1:0] OM_INTERF = 2'h0;
  localparam logic [1:0] OM_VLBI   = 2'h1;
  // 16-point cosine, amplitude 127
  localparam logic signed [7:0] COS_LUT [16] = '{
    8'sh7f, 8'sh75, 8'sh5a, 8'sh31, 8'sh00, -8'sh31, -8'sh5a, -8'sh75,
    -8'sh7f, -8'sh75, -8'sh5a, -8'sh31, 8'sh00, 8'sh31, 8'sh5a, 8'sh75};
endpackage

// ==== hw/sdpz_top.sv ====
// Sub-band reorder buffer, resampler, phase mixer and zoom decimator
`timescale 1ns/1ps

// Notes on behaviour
// (RQ1) Resample 250 MHz input to 256 MHz
// (RQ2) Delay drops 93.75 ps per input; the code applies the step once per output slot
// (RQ3) FIR coefficients reselected every output sample
// (RQ4) Bank holds 1024 filters over one sample
// (RQ5) Out of range: hold window, add sample
// (RQ6) Coarse delay via buffer read pointer
// (RQ7) Keep and accept last 250 ms
// (RQ8) Write packets at timestamp position
// (RQ9) Constant sets pointer, drift selects filter
// (RQ10) Derive first-order model in real time
// (RQ11) Model active from apply time onward
// (RQ12) Controller sends continuous long-lived models
// (RQ13) All timing follows distributed central time
// (RQ14) Phase model drives oscillator and mixer
// (RQ15) Zoom for resolution finer than channel
// (RQ16) Channelizer keeps 16384 channels, less bandwidth
// (RQ17) Zoom factors powers of two, 2-64
// (RQ18) Zoom is mixer then decimating FIR
// (RQ19) Decimator coefficients stored per zoom factor
// (RQ20) Zoom phase and frequency programmable
// (RQ21) Zoom only interferometric or VLBI mode
// (RQ22) Zoom oscillator merged with phase oscillator
// (RQ23) Valid per output, no consume when held
module sdpz_top #(
  parameter int          BUF_AW   = 26,
  parameter logic [47:0] LATE_WIN = 48'(sdpz_pkg::LATE_SAMP)
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Central time
  input  wire logic [47:0] ct_time,
  input  wire logic        ct_tick,
  // Incoming sub-band samples
  input  wire logic        in_valid,
  input  wire logic [47:0] in_ts,
  input  wire logic [15:0] in_data,
  // Conditioned output stream
  output logic             out_valid,
  output logic [31:0]      out_data,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  // Filter length and coefficient write fields, ahead of every use
  localparam int TAPS_W   = sdpz_pkg::TAPS;
  localparam int COEF_TAP = sdpz_pkg::COEF_TAP;
  localparam int COEF_IDX = sdpz_pkg::COEF_IDX;

  // Software settings
  logic              run_reg;
  logic              zen_reg;
  logic [1:0]        mode_reg;
  logic [2:0]        zlog_reg;
  logic [31:0]       c0_reg;
  logic [31:0]       c1_reg;
  logic [31:0]       c2_reg;
  logic [31:0]       ta_reg;
  logic [31:0]       phf_reg;
  logic [31:0]       php_reg;
  logic [31:0]       zmf_reg;
  logic [31:0]       zmp_reg;
  // Delay model state
  logic              pend_reg;
  logic              act_reg;
  logic [63:0]       d_reg;
  logic [47:0]       v_reg;
  // Buffer and resampler
  logic [15:0]       buf_mem [2**BUF_AW];
  logic [BUF_AW-1:0] rp_reg;
  logic [31:0]       r_reg;
  logic [TAPS_W-1:0][15:0] win_reg;
  logic [9:0]        fidx_reg;
  logic              s1_v_reg;
  logic signed [15:0] rs_i_reg;
  logic signed [15:0] rs_q_reg;
  logic              s2_v_reg;
  logic signed [15:0] rs_bank [sdpz_pkg::TAPS][sdpz_pkg::RS_BANK];
  // Oscillators, zoom
  logic [31:0]       ph_reg;
  logic [31:0]       zm_reg;
  logic [sdpz_pkg::TAPS-1:0][31:0] zwin_reg;
  logic              s3_v_reg;
  logic [5:0]        dcnt_reg;
  logic signed [15:0] zm_bank [sdpz_pkg::TAPS][8];
  logic [15:0]       drop_reg;

  // Bus strobes: a write lands on the edge that ends the request
  logic wr;
  assign wr = ce && avs_write && !avs_waitrequest;

  // Model switch takes place once central time reaches apply time;
  // the signed difference stays right across a wrap of the low time word
  logic ct_time_before;
  logic load;
  assign ct_time_before = $signed(ct_time[31:0] - ta_reg) < 0;
  assign load = ce && pend_reg && !(wr && avs_address == sdpz_pkg::REG_TAPPLY)
                && !ct_time_before; // [RQ11] [RQ13]

  // One output sample slot, paced by the central 256 MHz strobe
  logic tick;
  assign tick = ce && ct_tick && run_reg && act_reg; // [RQ1] [RQ13]

  // Packet age against central time
  logic [47:0] age;
  logic        late;
  assign age  = ct_time - in_ts;
  assign late = !age[47] && (age > LATE_WIN); // [RQ7]

  // Next residual delay: fixed step down plus model drift
  logic signed [33:0] rs_nxt;
  logic               hold;
  assign rs_nxt = $signed({2'b00, r_reg}) - $signed({2'b00, sdpz_pkg::RS_STEP})
                  + $signed({{2{v_reg[47]}}, v_reg[47:16]}); // [RQ2] [RQ9]
  assign hold = rs_nxt[33]; // [RQ5]

  // Zoom selection
  logic       zoom_on;
  logic [2:0] zsel;
  logic [5:0] dmask;
  assign zsel = (zlog_reg > 3'(sdpz_pkg::ZM_MAX_LOG)) ? 3'(sdpz_pkg::ZM_MAX_LOG) : zlog_reg; // [RQ17]
  assign zoom_on = zen_reg && (zlog_reg != 3'h0)
                   && (mode_reg == sdpz_pkg::OM_INTERF || mode_reg == sdpz_pkg::OM_VLBI); // [RQ15] [RQ21]
  assign dmask = 6'((7'h1 << zsel) - 7'h1);

  // Bus handshake: one wait cycle, then the answer
  always_ff @(posedge clk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if (ce)
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  // Read data captured on the first edge of a read
  always_ff @(posedge clk)
  begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (ce && avs_read && avs_waitrequest)
    begin
      case (avs_address)
        sdpz_pkg::REG_CTRL:    avs_readdata <= {25'h0, zlog_reg, mode_reg, zen_reg, run_reg};
        sdpz_pkg::REG_STATUS:  avs_readdata <= {drop_reg, 13'h0, zoom_on, pend_reg, act_reg};
        sdpz_pkg::REG_C0:      avs_readdata <= c0_reg;
        sdpz_pkg::REG_C1:      avs_readdata <= c1_reg;
        sdpz_pkg::REG_C2:      avs_readdata <= c2_reg;
        sdpz_pkg::REG_TAPPLY:  avs_readdata <= ta_reg;
        sdpz_pkg::REG_PH_FREQ: avs_readdata <= phf_reg;
        sdpz_pkg::REG_PH_INIT: avs_readdata <= php_reg;
        sdpz_pkg::REG_ZM_FREQ: avs_readdata <= zmf_reg;
        sdpz_pkg::REG_ZM_INIT: avs_readdata <= zmp_reg;
        sdpz_pkg::REG_DELAY:   avs_readdata <= d_reg[63:32];
        sdpz_pkg::REG_TIME:    avs_readdata <= ct_time[31:0];
        // Coefficient ports and unmapped words read zero
        default:               avs_readdata <= 32'h0;
      endcase
    end
  end

  // Settings written by software
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {run_reg, zen_reg, mode_reg, zlog_reg} <= 7'h0;
      {c0_reg, c1_reg, c2_reg, ta_reg} <= 128'h0;
      {phf_reg, php_reg, zmf_reg, zmp_reg} <= 128'h0;
    end
    else if (wr)
    begin
      case (avs_address)
        sdpz_pkg::REG_CTRL:
        begin
          run_reg  <= avs_writedata[sdpz_pkg::CTRL_RUN];
          zen_reg  <= avs_writedata[sdpz_pkg::CTRL_ZEN];
          mode_reg <= avs_writedata[sdpz_pkg::CTRL_MODE +: 2];
          zlog_reg <= avs_writedata[sdpz_pkg::CTRL_ZLOG +: 3];
        end
        sdpz_pkg::REG_C0:      c0_reg  <= avs_writedata;
        sdpz_pkg::REG_C1:      c1_reg  <= avs_writedata;
        sdpz_pkg::REG_C2:      c2_reg  <= avs_writedata;
        sdpz_pkg::REG_TAPPLY:  ta_reg  <= avs_writedata;
        sdpz_pkg::REG_PH_FREQ: phf_reg <= avs_writedata;
        sdpz_pkg::REG_PH_INIT: php_reg <= avs_writedata;
        sdpz_pkg::REG_ZM_FREQ: zmf_reg <= avs_writedata; // [RQ20]
        sdpz_pkg::REG_ZM_INIT: zmp_reg <= avs_writedata; // [RQ20]
        default: ;
      endcase
    end
  end

  // Coefficient banks, written a tap at a time
  always_ff @(posedge clk)
  begin
    if (wr && avs_address == sdpz_pkg::REG_RS_COEF)
      rs_bank[avs_writedata[COEF_TAP +: 2]][avs_writedata[COEF_IDX +: 10]] <= avs_writedata[15:0]; // [RQ4]
    if (wr && avs_address == sdpz_pkg::REG_ZM_COEF)
      zm_bank[avs_writedata[COEF_TAP +: 2]][avs_writedata[COEF_IDX +: 3]] <= avs_writedata[15:0]; // [RQ19]
  end

  // Delay model: arm on apply-time write, switch at apply time, then step
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_reg <= 1'b0;
      act_reg  <= 1'b0;
      d_reg    <= 64'h0;
      v_reg    <= 48'h0;
    end
    else if (ce)
    begin
      if (wr && avs_address == sdpz_pkg::REG_TAPPLY)
        pend_reg <= 1'b1; // Arming wins over a same-cycle switch
      else if (load)
      begin
        pend_reg <= 1'b0;
        act_reg  <= 1'b1;
        d_reg    <= {c0_reg, 32'h0}; // [RQ11]
        v_reg    <= {c1_reg, 16'h0};
      end
      else if (tick)
      begin
        // Forward differences give value and slope each slot
        d_reg <= d_reg + {{16{v_reg[47]}}, v_reg}; // [RQ10]
        v_reg <= v_reg + {{16{c2_reg[31]}}, c2_reg}; // [RQ10]
      end
    end
  end

  // Input buffer, addressed by timestamp so late arrivals slot in order
  always_ff @(posedge clk)
  begin
    if (ce && in_valid && !late)
      buf_mem[in_ts[BUF_AW-1:0]] <= in_data; // [RQ8] [RQ7]
  end

  // Count of packets refused as too old, saturating
  always_ff @(posedge clk)
  begin
    if (rst)
      drop_reg <= 16'h0;
    else if (ce && in_valid && late && drop_reg != 16'hffff)
      drop_reg <= drop_reg + 16'h1; // [RQ7]
  end

  // Resampler front: read pointer, residual delay, filter window
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rp_reg   <= '0;
      r_reg    <= 32'h0;
      win_reg  <= '0;
      fidx_reg <= 10'h0;
      s1_v_reg <= 1'b0;
    end
    else if (ce)
    begin
      s1_v_reg <= tick && !load; // [RQ23]
      if (load)
      begin
        // Whole samples go to the pointer, fraction to the filter
        rp_reg <= BUF_AW'(ct_time - {{32{c0_reg[31]}}, c0_reg[31:16]}); // [RQ6] [RQ9]
        r_reg  <= {c0_reg[15:0], 16'h0};
      end
      else if (tick)
      begin
        r_reg    <= rs_nxt[31:0]; // Wraps up one sample when held [RQ5]
        fidx_reg <= rs_nxt[31:22]; // [RQ3] [RQ4]
        if (!hold)
        begin
          win_reg <= {win_reg[TAPS_W-2:0], buf_mem[rp_reg]};
          rp_reg  <= rp_reg + BUF_AW'(1); // [RQ23]
        end
      end
    end
  end

  // Time-variant FIR over the window with the selected filter
  logic signed [25:0] acc_i;
  logic signed [25:0] acc_q;
  always_comb
  begin
    acc_i = 26'h0;
    acc_q = 26'h0;
    for (int k = 0; k < TAPS_W; k++)
    begin
      acc_i = acc_i + 26'($signed(win_reg[k][15:8]) * rs_bank[k][fidx_reg]); // [RQ3]
      acc_q = acc_q + 26'($signed(win_reg[k][7:0]) * rs_bank[k][fidx_reg]);
    end
  end

  // Resampler result and oscillator phases
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {rs_i_reg, rs_q_reg} <= 32'h0;
      s2_v_reg <= 1'b0;
      ph_reg   <= 32'h0;
      zm_reg   <= 32'h0;
    end
    else if (ce)
    begin
      s2_v_reg <= s1_v_reg;
      if (s1_v_reg)
      begin
        rs_i_reg <= acc_i[25:10];
        rs_q_reg <= acc_q[25:10];
      end
      if (load)
      begin
        ph_reg <= php_reg;
        zm_reg <= zmp_reg; // [RQ20]
      end
      else if (s2_v_reg)
      begin
        ph_reg <= ph_reg + phf_reg; // [RQ14]
        zm_reg <= zm_reg + zmf_reg; // [RQ20]
      end
    end
  end

  // One oscillator carries fringe phase plus zoom tuning
  logic [31:0]       phs;
  logic signed [7:0] nc;
  logic signed [7:0] ns;
  logic signed [24:0] mi;
  logic signed [24:0] mq;
  assign phs = ph_reg + (zoom_on ? zm_reg : 32'h0); // [RQ22] [RQ18]
  assign nc  = sdpz_pkg::COS_LUT[phs[31:28]];
  assign ns  = sdpz_pkg::COS_LUT[4'(phs[31:28] + 4'hc)];
  assign mi  = 25'(rs_i_reg * nc) - 25'(rs_q_reg * ns); // [RQ14]
  assign mq  = 25'(rs_i_reg * ns) + 25'(rs_q_reg * nc);

  // Mixed samples into the decimator window
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      zwin_reg <= '0;
      s3_v_reg <= 1'b0;
      dcnt_reg <= 6'h0;
    end
    else if (ce)
    begin
      s3_v_reg <= s2_v_reg;
      if (s2_v_reg)
      begin
        zwin_reg <= {zwin_reg[TAPS_W-2:0], mi[22:7], mq[22:7]};
        dcnt_reg <= dcnt_reg + 6'h1;
      end
    end
  end

  // Anti-alias FIR with the entry for this zoom factor
  logic signed [33:0] zacc_i;
  logic signed [33:0] zacc_q;
  always_comb
  begin
    zacc_i = 34'h0;
    zacc_q = 34'h0;
    for (int k = 0; k < TAPS_W; k++)
    begin
      zacc_i = zacc_i + 34'($signed(zwin_reg[k][31:16]) * zm_bank[k][zsel]); // [RQ19]
      zacc_q = zacc_q + 34'($signed(zwin_reg[k][15:0]) * zm_bank[k][zsel]);
    end
  end

  // Output: every sample, or one in 2^zsel when zooming
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= 32'h0;
    end
    else if (ce)
    begin
      out_valid <= 1'b0;
      if (s3_v_reg && !zoom_on)
      begin
        out_valid <= 1'b1; // [RQ23]
        out_data  <= zwin_reg[0];
      end
      else if (s3_v_reg && (dcnt_reg & dmask) == 6'h0)
      begin
        // Fewer samples, same channel count downstream [RQ16] [RQ18]
        out_valid <= 1'b1;
        out_data  <= {zacc_i[30:15], zacc_q[30:15]};
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_step_fixed: assert property (tick && !load && !hold && v_reg == 48'h0 |=> // [RQ2]
    r_reg == $past(r_reg) - sdpz_pkg::RS_STEP) else $error("residual step wrong");
  a_hold_window: assert property (tick && !load && hold |=> // [RQ5]
    $stable(win_reg) && rp_reg == $past(rp_reg)) else $error("window moved on hold");
  a_consume_one: assert property (tick && !load && !hold |=> // [RQ23]
    rp_reg == $past(rp_reg) + BUF_AW'(1)) else $error("pointer not advanced");
  a_out_latency: assert property (tick && !load && !zoom_on ##1 (ce && !zoom_on)[*3] |=> // [RQ23]
    out_valid) else $error("output strobe missing");
  a_late_count: assert property (ce && in_valid && late && drop_reg != 16'hffff |=> // [RQ7]
    drop_reg == $past(drop_reg) + 16'h1) else $error("late packet not counted");
  a_model_switch: assert property (load |=> // [RQ11]
    act_reg && !pend_reg && d_reg == {$past(c0_reg), 32'h0}) else $error("model not applied");
  a_ptr_from_model: assert property (load |=> // [RQ9]
    rp_reg == BUF_AW'($past(ct_time) - {{32{$past(c0_reg[31])}}, $past(c0_reg[31:16])}))
    else $error("read pointer not from model");
  a_phase_step: assert property (ce && s2_v_reg && !load |=> // [RQ14]
    ph_reg == $past(ph_reg) + $past(phf_reg)) else $error("phase not advanced");
  a_zoom_mode: assert property (ce && s3_v_reg && mode_reg[1] |=> // [RQ21]
    out_valid) else $error("zoom decimating outside allowed modes");
  a_zoom_decim: assert property (ce && out_valid && zoom_on && zsel == 3'h1 |=> // [RQ17]
    !out_valid) else $error("zoom by two not decimating");

  c_hold: cover property (tick && hold);
  c_zoom_out: cover property (out_valid && zoom_on);
  c_model: cover property (load);
endmodule
